// [hw/tmc_ch0_io_irq.sv]
// Purpose: channel 0 pin-function control, match flags and interrupt enables
//          of a 16-bit timer, with an APB register port.
// Assumes: counter and overflow event come from outside; inputs synchronous.
// Notes:   every top output is a flip-flop; APB answers one cycle after
//          the access phase opens.
`timescale 1ns/1ps
module tmc_ch0_io_irq import tmc_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [GR_W-1:0]   timer_count,
  input  wire logic              count_tick,
  input  wire logic              overflow_event,
  input  wire logic              cap_a_in,
  input  wire logic              cap_b_in,
  output logic                   pin_a_out,
  output logic                   pin_a_oe,
  output logic                   pin_b_out,
  output logic                   pin_b_oe,
  output logic                   a_match_irq,
  output logic                   b_match_irq,
  output logic                   overflow_irq,
  output logic                   irq
);

  // software-visible state, plus clear_armed which software cannot read
  logic [2:0]      a_function;
  logic [2:0]      b_function;
  logic [2:0]      irq_enable;
  logic [2:0]      flags;
  logic [2:0]      clear_armed;

  // bus decode
  wire access   = psel & penable;
  wire finish   = access & pready;
  wire wr_fire  = finish & pwrite;
  wire rd_load  = access & ~pready & ~pwrite;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_ien  = (paddr == ADDR_IEN);
  wire hit_flag = (paddr == ADDR_FLAG);
  wire hit_gra  = (paddr == ADDR_GRA);
  wire hit_grb  = (paddr == ADDR_GRB);
  wire mapped   = hit_ctrl | hit_ien | hit_flag | hit_gra | hit_grb;

  // channel array, A at index 0, B at index 1
  logic [2:0]      ch_func  [2];
  logic [GR_W-1:0] ch_wdata [2];
  logic [GR_W-1:0] ch_gr    [2];
  logic            ch_cap   [2];
  logic            ch_wr    [2];
  logic            ch_hit   [2];
  logic            ch_pin   [2];
  logic            ch_oe    [2];

  assign ch_func[0] = a_function;
  assign ch_func[1] = b_function;
  assign ch_cap[0]  = cap_a_in;
  assign ch_cap[1]  = cap_b_in;
  assign ch_wr[0]   = wr_fire & hit_gra;
  assign ch_wr[1]   = wr_fire & hit_grb;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign ch_wdata[gi] = pwdata[GR_W-1:0];
      tmc_channel u_ch (
        .clk        (clk),
        .rstn       (rstn),
        .func       (ch_func[gi]),
        .count      (timer_count),
        .count_tick (count_tick),
        .cap_in     (ch_cap[gi]),
        .wr_en      (ch_wr[gi]),
        .wr_data    (ch_wdata[gi]),
        .gr         (ch_gr[gi]),
        .hit        (ch_hit[gi]),
        .pin_out    (ch_pin[gi]),
        .pin_oe     (ch_oe[gi])
      );
    end
  endgenerate

  // events by flag bit position
  wire [2:0] events = {overflow_event, ch_hit[1], ch_hit[0]};

  // control register: A field bits 2..0, B field bits 6..4
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_function <= CTRL_RESET[A_FN_LSB +: FN_W];
      b_function <= CTRL_RESET[B_FN_LSB +: FN_W];
    end else if (wr_fire && hit_ctrl) begin
      a_function <= pwdata[A_FN_LSB +: FN_W];
      b_function <= pwdata[B_FN_LSB +: FN_W];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable <= IEN_RESET;
    end else if (wr_fire && hit_ien) begin
      irq_enable <= pwdata[2:0];
    end
  end

  // flag clear needs a prior read that saw the bit set; writing one
  // does nothing. a new event in the clearing cycle keeps the flag.
  wire       flag_wr   = wr_fire & hit_flag;
  wire [2:0] clear_req = flag_wr ? (clear_armed & ~pwdata[2:0]) : 3'h0;
  wire [2:0] next_flags = events | (flags & ~clear_req);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // arm with the very value the read returns, so a flag set while the
  // read is in flight cannot be cleared unseen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clear_armed <= 3'h0;
    end else if (rd_load && hit_flag) begin
      clear_armed <= flags;
    end else if (flag_wr) begin
      clear_armed <= 3'h0;
    end
  end

  // requests pass through their enable
  wire [2:0] next_req = next_flags & irq_enable;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_match_irq  <= 1'b0;
      b_match_irq  <= 1'b0;
      overflow_irq <= 1'b0;
      irq          <= 1'b0;
    end else begin
      a_match_irq  <= next_req[BIT_A];
      b_match_irq  <= next_req[BIT_B];
      overflow_irq <= next_req[BIT_OVF];
      irq          <= |next_req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_out <= 1'b0;
      pin_a_oe  <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe  <= 1'b0;
    end else begin
      pin_a_out <= ch_pin[0];
      pin_a_oe  <= ch_oe[0];
      pin_b_out <= ch_pin[1];
      pin_b_oe  <= ch_oe[1];
    end
  end

  // read mux; unused bits of the 8-bit registers read one
  wire [7:0] ctrl_rd = CTRL_FIXED | {1'b0, b_function, 1'b0, a_function};
  wire [7:0] ien_rd  = LOW3_FIXED | {5'h00, irq_enable};
  wire [7:0] flag_rd = LOW3_FIXED | {5'h00, flags};

  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata = {24'h00_0000, ctrl_rd};
    end else if (hit_ien) begin
      next_rdata = {24'h00_0000, ien_rd};
    end else if (hit_flag) begin
      next_rdata = {24'h00_0000, flag_rd};
    end else if (hit_gra) begin
      next_rdata = {16'h0000, ch_gr[0]};
    end else if (hit_grb) begin
      next_rdata = {16'h0000, ch_gr[1]};
    end
  end

  // ready one cycle into the access phase, then dropped for one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (rd_load) begin
        prdata <= next_rdata;
      end
    end
  end

endmodule

// [hw/tmc_pkg.sv]
// Purpose: constants, types and decoders for the channel 0 pin-function and
//          interrupt-enable block of a 16-bit timer.
// Assumes: APB with 32-bit data; each 8-bit register sits in one word.
// Notes:   register byte address is four times the register index.
//
// Behaviour
// - A code 000..011: compare; no pin change, drive low, high, toggle.
// - A code 100 captures counter on rising, 101 on falling input edge.
// - A code 110 captures counter into A on both input edges.
// - B code 000..011: compare; no pin change, drive low, high, toggle.
// - B code 100 captures counter on rising, 101 on falling input edge.
// - B code 110 captures counter into B on both input edges.
// - A code sits in control bits 2..0; bit 2 selects capture.
// - B code sits in control bits 6..4; bits 7 and 3 read one.
// - A request passes only while enable bit 0 is one; resets zero.
// - B request passes only while enable bit 1 is one; resets zero.
// - Overflow request passes only while enable bit 2 is one.
// - A flag sets on compare equality or on capture into A.
// - B flag sets on compare equality or on capture into B.
package tmc_pkg;

  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned GR_W     = 16;
  localparam int unsigned FN_W     = 3;

  // register indices; byte address is index times four
  localparam logic [9:0] IDX_CTRL = 10'h065;
  localparam logic [9:0] IDX_IEN  = 10'h066;
  localparam logic [9:0] IDX_FLAG = 10'h067;
  localparam logic [9:0] IDX_GRA  = 10'h068;
  localparam logic [9:0] IDX_GRB  = 10'h06C;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IEN  = {IDX_IEN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GRA  = {IDX_GRA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GRB  = {IDX_GRB, 2'b00};

  // field positions
  localparam int unsigned A_FN_LSB   = 0;
  localparam int unsigned B_FN_LSB   = 4;
  localparam int unsigned BIT_A      = 0;
  localparam int unsigned BIT_B      = 1;
  localparam int unsigned BIT_OVF    = 2;

  // reset values and read masks
  localparam logic [7:0] CTRL_RESET  = 8'h88;
  localparam logic [7:0] CTRL_FIXED  = 8'h88;
  localparam logic [7:0] LOW3_FIXED  = 8'hF8;
  localparam logic [2:0] IEN_RESET   = 3'h0;
  localparam logic [2:0] FLAG_RESET  = 3'h0;
  localparam logic [15:0] GR_RESET   = 16'hFFFF;

  typedef enum logic [2:0] {
    FN_CMP_NONE  = 3'h0,
    FN_CMP_LOW   = 3'h1,
    FN_CMP_HIGH  = 3'h2,
    FN_CMP_TOG   = 3'h3,
    FN_CAP_RISE  = 3'h4,
    FN_CAP_FALL  = 3'h5,
    FN_CAP_BOTH  = 3'h6,
    FN_CAP_BOTH2 = 3'h7
  } tmc_fn_type;

  function automatic logic fn_is_capture(input logic [2:0] fn);
    fn_is_capture = fn[2];
  endfunction

  // edge selection for capture codes
  function automatic logic fn_capture_hit(input logic [2:0] fn,
                                          input logic       rise,
                                          input logic       fall);
    logic hit;
    hit = 1'b0;
    unique case (tmc_fn_type'(fn))
      FN_CAP_RISE:  hit = rise;
      FN_CAP_FALL:  hit = fall;
      FN_CAP_BOTH:  hit = rise | fall;
      FN_CAP_BOTH2: hit = rise | fall;
      FN_CMP_NONE, FN_CMP_LOW, FN_CMP_HIGH, FN_CMP_TOG: hit = 1'b0;
    endcase
    fn_capture_hit = hit;
  endfunction

endpackage

// [hw/tmc_channel.sv]
// Purpose: one general register working as compare or capture register.
// Assumes: count and cap_in are synchronous to clk.
// Notes:   capture beats a software write landing in the same cycle.
`timescale 1ns/1ps
module tmc_channel import tmc_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic [2:0]      func,
  input  wire logic [GR_W-1:0] count,
  input  wire logic            count_tick,
  input  wire logic            cap_in,
  input  wire logic            wr_en,
  input  wire logic [GR_W-1:0] wr_data,
  output logic      [GR_W-1:0] gr,
  output logic                 hit,
  output logic                 pin_out,
  output logic                 pin_oe
);

  logic cap_prev;

  wire rise    = cap_in & ~cap_prev;
  wire fall    = ~cap_in & cap_prev;
  // capture on selected edge, 111 falls into both-edge case
  wire cap_hit = fn_capture_hit(func, rise, fall);
  // compare only on a counter step, so a stopped counter matches once
  wire cmp_hit = ~fn_is_capture(func) & count_tick & (count == gr);

  logic next_pin;
  always_comb begin
    next_pin = pin_out;
    if (cmp_hit) begin
      unique case (func[1:0])
        2'h0: next_pin = pin_out;
        2'h1: next_pin = 1'b0;
        2'h2: next_pin = 1'b1;
        2'h3: next_pin = ~pin_out;
      endcase
    end
  end

  assign hit = cap_hit | cmp_hit;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= cap_in;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gr <= GR_RESET;
    end else if (cap_hit) begin
      gr <= count;
    end else if (wr_en) begin
      gr <= wr_data;
    end
  end

  // pin level is kept while in capture mode; only enable drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= next_pin;
      pin_oe  <= ~fn_is_capture(func) & (func[1:0] != 2'h0);
    end
  end

endmodule

// [tb/tmc_far_side.sv]
// Purpose: counter side of the timer feeding channel 0.
// Assumes: one clock; load gives no tick, so a load never matches.
// Notes:   overflow pulses in the cycle the count wraps to zero.
`timescale 1ns/1ps
module tmc_far_side import tmc_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            run,
  input  wire logic            load,
  input  wire logic [GR_W-1:0] load_val,
  output logic      [GR_W-1:0] count,
  output logic                 tick,
  output logic                 ovf
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      tick  <= 1'b0;
      ovf   <= 1'b0;
    end else begin
      tick  <= run & ~load;
      ovf   <= run & ~load & (count == 16'hFFFF);
      count <= load ? load_val : count + {15'h0, run};
    end
  end
endmodule

// [tb/tmc_ch0_io_irq_asserts.sv]
// Purpose: port-level checks of the channel 0 block.
// Assumes: enable latency may be one or two edges.
// Notes:   pins may only move after a counter tick.
`timescale 1ns/1ps
module tmc_ch0_io_irq_asserts import tmc_pkg::*; (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [GR_W-1:0]   timer_count,
  input wire logic              count_tick,
  input wire logic              overflow_event,
  input wire logic              cap_a_in,
  input wire logic              cap_b_in,
  input wire logic              pin_a_out,
  input wire logic              pin_a_oe,
  input wire logic              pin_b_out,
  input wire logic              pin_b_oe,
  input wire logic              a_match_irq,
  input wire logic              b_match_irq,
  input wire logic              overflow_irq,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic any;
  logic wrd;
  assign any = a_match_irq | b_match_irq | overflow_irq;
  assign wrd = pready & pwrite;
  AST_READY_ONE_CYCLE: assert property (
    psel && $rose(penable) |=> pready ##1 !pready)
    else $error("pready not a single cycle after access");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_IRQ_FROM_SOURCE: assert property (
    $rose(irq) |-> any || $past(any)) else $error("irq without source");
  AST_OVF_IRQ_CAUSE: assert property ($rose(overflow_irq) |->
    $past(overflow_event) || $past(wrd) || $past(wrd, 2))
    else $error("overflow irq without event or enable");
  AST_A_IRQ_FALL: assert property ($fell(a_match_irq) |->
    $past(wrd) || $past(wrd, 2)) else $error("a irq dropped unasked");
  AST_B_IRQ_FALL: assert property ($fell(b_match_irq) |->
    $past(wrd) || $past(wrd, 2)) else $error("b irq dropped unasked");
  AST_PIN_A_HOLD: assert property (
    $changed(pin_a_out) |-> $past(count_tick, 2))
    else $error("pin a moved without match");
  AST_PIN_B_HOLD: assert property (
    $changed(pin_b_out) |-> $past(count_tick, 2))
    else $error("pin b moved without match");
  cover property (pslverr);
  cover property ($fell(a_match_irq));
  cover property ($rose(overflow_irq));
endmodule
bind tmc_ch0_io_irq tmc_ch0_io_irq_asserts tmc_ch0_io_irq_asserts_i (.*);

// [tb/test_timer_channel_io_and_irq_enable.sv]
// Purpose: self-checking bench for channel 0 control and interrupts.
// Assumes: reads are checked from a queue at the falling edge.
// Notes:   both capture pins share one stimulus line.
`timescale 1ns/1ps
module test_timer_channel_io_and_irq_enable import tmc_pkg::*;;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        cap = 1'b0;
  logic        run = 1'b0;
  logic        load = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [15:0] lval = '0;
  logic        pready, pslverr, tick, ovf, pao, paoe, pbo, pboe;
  logic        airq, birq, oirq, irq;
  logic [31:0] prdata;
  logic [15:0] cnt, v1, v2, w;
  logic [2:0]  c;
  logic [32:0] expq[$];
  int          seed = 82135;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  tmc_far_side tmc_far_side_i (.clk(clk), .rstn(rstn), .run(run),
    .load(load), .load_val(lval), .count(cnt), .tick(tick), .ovf(ovf));
  tmc_ch0_io_irq tmc_ch0_io_irq_i (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_count(cnt), .count_tick(tick), .overflow_event(ovf),
    .cap_a_in(cap), .cap_b_in(cap), .pin_a_out(pao), .pin_a_oe(paoe),
    .pin_b_out(pbo), .pin_b_oe(pboe), .a_match_irq(airq),
    .b_match_irq(birq), .overflow_irq(oirq), .irq(irq));
  always #10 clk = ~clk;
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d of %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic we, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    if (!we) expq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, '0, e);
  endtask
  task automatic ld(input logic [15:0] v);
    @(posedge clk);
    lval <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  always @(negedge clk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_CTRL, 33'h088);
    rd(ADDR_IEN, 33'h0F8);
    rd(ADDR_FLAG, 33'h0F8);
    rd(ADDR_GRA, 33'h0FFFF);
    rd(12'h1FC, 33'h100000000);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w = 16'($random(seed)) & 16'h7FFF;
      wr(ADDR_CTRL, {25'h0, c, 1'b0, c});
      rd(ADDR_CTRL, {25'h0, 1'b1, c, 1'b1, c});
      wr(ADDR_IEN, {30'h0, c[1:0]});
      rd(ADDR_IEN, {25'h0, 6'h3E, c[1:0]});
      if (!c[2]) begin
        ld(w);
        wr(ADDR_GRA, {16'h0, w + 16'h0005});
        wr(ADDR_GRB, {16'h0, w + 16'h0009});
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(negedge clk);
        if (c != 0) chk({31'h0, pao, pbo},
                        {31'h0, {2{c == 3'h2}}});
        rd(ADDR_GRA, {17'h0, w + 16'h0005});
      end else begin
        v1 = 16'($random(seed));
        v2 = 16'($random(seed));
        wr(ADDR_GRA, {16'h0, w});
        wr(ADDR_GRB, {16'h0, w});
        ld(v1);
        cap <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_GRA, {17'h0, c == 3'h5 ? w : v1});
        rd(ADDR_GRB, {17'h0, c == 3'h5 ? w : v1});
        ld(v2);
        cap <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_GRA, {17'h0, c == 3'h4 ? v1 : v2});
        rd(ADDR_GRB, {17'h0, c == 3'h4 ? v1 : v2});
      end
      @(negedge clk);
      chk({31'h0, paoe, pboe}, {31'h0, {2{c > 0 && c < 4}}});
      chk({30'h0, airq, birq, irq},
          {30'h0, c[0], c[1], |c[1:0]});
      rd(ADDR_FLAG, 33'h0FB);
      wr(ADDR_FLAG, 32'hFF);
      rd(ADDR_FLAG, 33'h0FB);
      wr(ADDR_FLAG, 32'h0);
      rd(ADDR_FLAG, 33'h0F8);
    end
    wr(ADDR_IEN, 32'h0);
    ld(16'hFFFE);
    run <= 1'b1;
    repeat (4) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(negedge clk);
    chk({32'h0, oirq}, 33'h0);
    wr(ADDR_IEN, 32'h4);
    repeat (2) @(negedge clk);
    chk({31'h0, oirq, irq}, 33'h3);
    rd(ADDR_FLAG, 33'h0FC);
    wr(ADDR_FLAG, 32'h0);
    repeat (2) @(negedge clk);
    chk({32'h0, irq}, 33'h0);
    end_sim();
  end
endmodule
